// ### include/ccr_defines.vh
// Offsets, field positions, reset values and timing counts of the connectivity control register
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

`define CCR_ADDR_W 6
`define CCR_OFFSET 6'h05
`define CCR_WIDTH 24
// Bits 17 and 18 come from the strap instead of this value
`define CCR_RESET_VAL 24'h080060

`define CCR_BIT_DP_VAR_PU 2
`define CCR_BIT_DP_PD 3
`define CCR_BIT_DM_PD 4
`define CCR_VTMR_LSB 7
`define CCR_VTMR_MSB 9
`define CCR_BIT_DLP_EN 10
`define CCR_BIT_AUTO_PU 11
`define CCR_BIT_XCVR_EN 12
`define CCR_BIT_PULL_OVR 13
`define CCR_MODE_LSB 14
`define CCR_MODE_MSB 16
`define CCR_BIT_COMB_SIG 17
`define CCR_BIT_DIR_SEL 18
`define CCR_BIT_XCVR_SEL 19
`define CCR_BIT_IDENT_LINE_PULLDOWN 20
`define CCR_BIT_IDENT_LINE_GROUND_PULSE 21
`define CCR_BIT_ID_PU_SRC 22
`define CCR_BIT_MINUS_LINE_PULSE 23

`define CCR_MODE_USB 3'h0
`define CCR_VTMR_OFF 3'h0
`define CCR_VTMR_CONT 3'h7

// Timing: clock rate, limit timer step, line pulse width
`define CCR_CLK_KHZ 40000
`define CCR_VTMR_STEP_MS 10
// Cycle counts sized to the timer: 10 ms and 10 us at 40 MHz
`define CCR_VTMR_STEP_CYC 24'h061A80
`define CCR_LINE_PULSE_US 10
`define CCR_LINE_PULSE_CYC 24'h000190
`define CCR_TMR_W 24

`endif

// ### hdl/ccr_timer.v
// One-shot down counter used for the limit timer and the line pulses
`timescale 1ns/1ps
module ccr_timer (
	// Clock and reset
	input wire clk_sys_i,
	input wire sys_rst_i,
	// Control
	input wire start_i,
	input wire stop_i,
	input wire [23:0] load_i,
	// Status
	output wire busy_o
);

	reg [23:0] count_q;

	// Start reloads even while busy, so a rewrite restarts the interval
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_q <= 24'h000000;
		end else if (start_i) begin
			count_q <= load_i;
		end else if (stop_i) begin
			count_q <= 24'h000000;
		end else if (count_q != 24'h000000) begin
			count_q <= count_q - 24'h000001;
		end
	end

	assign busy_o = (count_q != 24'h000000);

endmodule

// ### hdl/ccr_regs.v
// Connectivity control register with its steering logic
`timescale 1ns/1ps
`include "ccr_defines.vh"
module ccr_regs #(
	parameter [23:0] VTMR_STEP_CYC = `CCR_VTMR_STEP_CYC,
	parameter [23:0] LINE_PULSE_CYC = `CCR_LINE_PULSE_CYC
) (
	// Clock and reset
	input wire clk_sys_i,
	input wire sys_rst_i,
	// Register port from the serial interface decoder
	input wire [5:0] reg_addr_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [23:0] reg_wdata_i,
	output reg [23:0] reg_rdata_o,
	// Neighbouring control, same clock
	input wire boost_output_enable_i,
	// Pins, asynchronous
	input wire boot_strap_pin_i,
	input wire reset_low_pin_i,
	input wire usb_enable_pin_i,
	input wire transmit_enable_low_i,
	input wire line_se0_i,
	// Regulator control
	output wire five_volt_regulator_on_o,
	output wire limit_200ma_o,
	output wire limit_910ua_o,
	// Transceiver and line control
	output wire data_line_pulse_timer_enable_o,
	output wire transceiver_enable_o,
	output wire dp_var_pullup_o,
	output wire dp_pulldown_o,
	output wire dm_pulldown_o,
	output wire [2:0] interface_mode_o,
	output wire combined_data_signalling_o,
	output wire direction_select_o,
	// Identification and minus line
	output wire ident_line_pulldown_o,
	output wire ident_line_ground_pulse_o,
	output wire ident_pullup_source_select_o,
	output wire minus_line_pulse_o
);

	reg [23:0] ctrl_q;
	reg [1:0] strap_sync_q;
	reg [1:0] rstb_sync_q;
	reg [1:0] usben_sync_q;
	reg [1:0] transmit_enable_low_sync_q;
	reg [1:0] se0_sync_q;
	reg [1:0] strap_wait_q;
	reg strap_done_q;
	reg vtmr_cont_q;
	reg ident_line_ground_pulse_prev_q;
	reg minus_line_pulse_prev_q;
	wire reg_sel;
	wire reg_wr;
	wire [2:0] vtmr_code;
	wire vtmr_start;
	wire vtmr_busy;
	wire id_busy;
	wire dm_busy;
	wire usb_mode;
	wire txen_active;
	wire pulls_dropped;
	wire var_pullup_base;

	// Limit interval for codes 1 to 6, code times the step
	function [23:0] ccr_vtmr_load;
		input [2:0] code;
		input [23:0] step;
		begin
			ccr_vtmr_load = step * {21'h0, code};
		end
	endfunction

	assign reg_sel = (reg_addr_i == `CCR_OFFSET);
	assign reg_wr = reg_wr_i & reg_sel;
	assign vtmr_code = ctrl_q[`CCR_VTMR_MSB:`CCR_VTMR_LSB];

	// Pin synchronisers, second stage is the only reader of the first
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap_sync_q <= 2'h0;
			rstb_sync_q <= 2'h0;
			usben_sync_q <= 2'h0;
			transmit_enable_low_sync_q <= 2'h3;
			se0_sync_q <= 2'h0;
		end else begin
			strap_sync_q <= {strap_sync_q[0], boot_strap_pin_i};
			rstb_sync_q <= {rstb_sync_q[0], reset_low_pin_i};
			usben_sync_q <= {usben_sync_q[0], usb_enable_pin_i};
			transmit_enable_low_sync_q <= {transmit_enable_low_sync_q[0], transmit_enable_low_i};
			se0_sync_q <= {se0_sync_q[0], line_se0_i};
		end
	end

	// Strap is caught once the synchroniser has filled after release
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			strap_wait_q <= 2'h0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_wait_q <= strap_wait_q + 2'h1;
			if (strap_wait_q == 2'h2) begin
				strap_done_q <= 1'b1;
			end
		end
	end

	// Register storage; strap load takes the two style bits once
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q <= `CCR_RESET_VAL;
		end else begin
			if (reg_wr) begin
				ctrl_q <= reg_wdata_i;
			end
			if (!strap_done_q && strap_wait_q == 2'h2) begin
				ctrl_q[`CCR_BIT_COMB_SIG] <= strap_sync_q[1];
				ctrl_q[`CCR_BIT_DIR_SEL] <= strap_sync_q[1];
			end
		end
	end

	// Registered read data, unmapped addresses read zero
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 24'h000000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= reg_sel ? ctrl_q : 24'h000000;
		end
	end

	// Limit timer starts on every write of a finite code
	assign vtmr_start = reg_wr && (reg_wdata_i[`CCR_VTMR_MSB:`CCR_VTMR_LSB] != `CCR_VTMR_OFF) &&
		(reg_wdata_i[`CCR_VTMR_MSB:`CCR_VTMR_LSB] != `CCR_VTMR_CONT);

	// Code 7 has no printed interval, so it holds the limit until rewritten
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			vtmr_cont_q <= 1'b0;
		end else if (reg_wr) begin
			vtmr_cont_q <= (reg_wdata_i[`CCR_VTMR_MSB:`CCR_VTMR_LSB] == `CCR_VTMR_CONT);
		end
	end

	ccr_timer u_vtmr (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.start_i(vtmr_start),
		.stop_i(reg_wr),
		.load_i(ccr_vtmr_load(reg_wdata_i[`CCR_VTMR_MSB:`CCR_VTMR_LSB], VTMR_STEP_CYC)),
		.busy_o(vtmr_busy)
	);

	// Regulator: enable wins, else on while the timer runs or code 7 holds the limit
	assign five_volt_regulator_on_o = boost_output_enable_i | vtmr_busy | vtmr_cont_q;
	assign limit_910ua_o = !boost_output_enable_i & (vtmr_busy | vtmr_cont_q);
	assign limit_200ma_o = !boost_output_enable_i & (vtmr_code == `CCR_VTMR_OFF);

	assign data_line_pulse_timer_enable_o = ctrl_q[`CCR_BIT_DLP_EN];
	assign interface_mode_o = ctrl_q[`CCR_MODE_MSB:`CCR_MODE_LSB];
	assign combined_data_signalling_o = ctrl_q[`CCR_BIT_COMB_SIG];
	assign direction_select_o = ctrl_q[`CCR_BIT_DIR_SEL];
	assign ident_line_pulldown_o = ctrl_q[`CCR_BIT_IDENT_LINE_PULLDOWN];
	assign ident_pullup_source_select_o = ctrl_q[`CCR_BIT_ID_PU_SRC];

	// Transceiver: mode USB and reset released, then bit or pin
	assign usb_mode = (interface_mode_o == `CCR_MODE_USB);
	assign transceiver_enable_o = usb_mode & rstb_sync_q[1] &
		(ctrl_q[`CCR_BIT_XCVR_EN] | (ctrl_q[`CCR_BIT_XCVR_SEL] & usben_sync_q[1]));

	// Pull network: override drops pulls during transmit
	assign txen_active = !transmit_enable_low_sync_q[1];
	assign pulls_dropped = ctrl_q[`CCR_BIT_PULL_OVR] & txen_active;
	assign var_pullup_base = (ctrl_q[`CCR_BIT_XCVR_SEL] ? usben_sync_q[1] : ctrl_q[`CCR_BIT_DP_VAR_PU]) |
		(ctrl_q[`CCR_BIT_AUTO_PU] & se0_sync_q[1]);
	assign dp_var_pullup_o = var_pullup_base & !pulls_dropped;
	assign dp_pulldown_o = ctrl_q[`CCR_BIT_DP_PD] & !pulls_dropped;
	assign dm_pulldown_o = ctrl_q[`CCR_BIT_DM_PD] & !pulls_dropped;

	// Line pulses fire on the rising edge of their bit; a held bit does not repeat
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ident_line_ground_pulse_prev_q <= 1'b0;
			minus_line_pulse_prev_q <= 1'b0;
		end else begin
			ident_line_ground_pulse_prev_q <= ctrl_q[`CCR_BIT_IDENT_LINE_GROUND_PULSE];
			minus_line_pulse_prev_q <= ctrl_q[`CCR_BIT_MINUS_LINE_PULSE];
		end
	end

	ccr_timer u_ident_line_ground_pulse (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.start_i(ctrl_q[`CCR_BIT_IDENT_LINE_GROUND_PULSE] & !ident_line_ground_pulse_prev_q),
		.stop_i(!ctrl_q[`CCR_BIT_IDENT_LINE_GROUND_PULSE]),
		.load_i(LINE_PULSE_CYC),
		.busy_o(id_busy)
	);

	ccr_timer u_minus_line_pulse (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.start_i(ctrl_q[`CCR_BIT_MINUS_LINE_PULSE] & !minus_line_pulse_prev_q),
		.stop_i(!ctrl_q[`CCR_BIT_MINUS_LINE_PULSE]),
		.load_i(LINE_PULSE_CYC),
		.busy_o(dm_busy)
	);

	assign ident_line_ground_pulse_o = id_busy;
	assign minus_line_pulse_o = dm_busy;

endmodule

// ### testbench/ccr_props.sv
// Port checker for the connectivity control register
`timescale 1ns/1ps
module ccr_props #(
	parameter [23:0] VTMR_STEP_CYC = 24'h000014,
	parameter [23:0] LINE_PULSE_CYC = 24'h000004
) (
	// Clock, reset, register port
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire [5:0] reg_addr_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [23:0] reg_wdata_i,
	input wire [23:0] reg_rdata_o,
	// Pins and controls
	input wire boost_output_enable_i,
	input wire boot_strap_pin_i,
	input wire limit_200ma_o,
	input wire limit_910ua_o,
	input wire five_volt_regulator_on_o,
	input wire transceiver_enable_o,
	input wire [2:0] interface_mode_o,
	input wire data_line_pulse_timer_enable_o,
	input wire combined_data_signalling_o,
	input wire direction_select_o,
	input wire ident_line_pulldown_o,
	input wire ident_pullup_source_select_o,
	input wire ident_line_ground_pulse_o,
	input wire minus_line_pulse_o
);
	// Stored fields as they show on the outputs
	wire wr5 = reg_wr_i && reg_addr_i == 6'h05;
	wire wz = wr5 && reg_wdata_i[9:7] == 3'h0;
	wire [23:0] seen = {1'b0, ident_pullup_source_select_o, 1'b0, ident_line_pulldown_o, 1'b0, direction_select_o,
		combined_data_signalling_o, interface_mode_o, 3'h0, data_line_pulse_timer_enable_o, 10'h000};
	reg [23:0] gp_q;
	reg [23:0] mp_q;
	// Pulse widths; a counter, since the width is a parameter
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gp_q <= 24'h000000;
			mp_q <= 24'h000000;
		end else begin
			gp_q <= ident_line_ground_pulse_o ? gp_q + 24'h000001 : 24'h000000;
			mp_q <= minus_line_pulse_o ? mp_q + 24'h000001 : 24'h000000;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	a_field_follow: assert property ($past(wr5) |-> seen == ($past(reg_wdata_i) & 24'h57C400))
		else $error("field not taken");
	a_limit_zero: assert property ($past(wz) |-> limit_200ma_o != boost_output_enable_i && !limit_910ua_o)
		else $error("code zero limit wrong");
	a_boost_on: assert property (boost_output_enable_i |-> five_volt_regulator_on_o && !limit_200ma_o)
		else $error("boost not on");
	a_xcvr_mode: assert property (interface_mode_o != 3'h0 |-> !transceiver_enable_o)
		else $error("transceiver on outside usb");
	a_rd_back: assert property (reg_rd_i && reg_addr_i == 6'h05 |=> (reg_rdata_o & 24'h57C400) == seen)
		else $error("read differs");
	a_rd_unmapped: assert property (reg_rd_i && reg_addr_i != 6'h05 |=> reg_rdata_o == 24'h000000)
		else $error("unmapped read");
	a_ident_pulse: assert property ($fell(ident_line_ground_pulse_o) |-> gp_q == LINE_PULSE_CYC)
		else $error("ident pulse width");
	a_minus_pulse: assert property ($fell(minus_line_pulse_o) |-> mp_q == LINE_PULSE_CYC)
		else $error("minus pulse width");
	a_strap_load: assert property ($fell(sys_rst_i) |-> ##4 combined_data_signalling_o == boot_strap_pin_i
		&& direction_select_o == boot_strap_pin_i) else $error("strap not loaded");
	c_write: cover property (wr5);
	c_pulse: cover property ($rose(ident_line_ground_pulse_o));
	c_xcvr: cover property (transceiver_enable_o);
endmodule
bind ccr_regs ccr_props #(.VTMR_STEP_CYC(VTMR_STEP_CYC), .LINE_PULSE_CYC(LINE_PULSE_CYC)) u_props (.*);

// ### testbench/ccr_host.sv
// Host model driving the register port on falling edges
`timescale 1ns/1ps
module ccr_host (
	// Clock
	input wire clk_sys_i,
	// Register port
	output reg [5:0] reg_addr_o,
	output reg reg_wr_o,
	output reg reg_rd_o,
	output reg [23:0] reg_wdata_o,
	input wire [23:0] reg_rdata_i
);
	// Idle port at time zero
	initial begin
		reg_addr_o = 6'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 24'h000000;
	end
	// One-cycle strobe, whole 24-bit word
	task wr(input [5:0] a, input [23:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_o = 1'b0;
	endtask
	// Data is taken two cycles after the read strobe rises
	task rd(input [5:0] a, output [23:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(negedge clk_sys_i);
		reg_rd_o = 1'b0;
		@(negedge clk_sys_i);
		d = reg_rdata_i;
	endtask
endmodule

// ### testbench/tb_connectivity_control_register.sv
// Self-checking bench for the connectivity control register
`timescale 1ns/1ps
module tb_connectivity_control_register;
	reg clk_sys_i = 1'b0;
	reg sys_rst_i = 1'b1;
	reg boost = 1'b0;
	reg strap = 1'b1;
	reg rst_n_pin = 1'b1;
	reg usben = 1'b0;
	reg tx_en_n = 1'b1;
	reg se0 = 1'b0;
	wire [5:0] addr;
	wire [23:0] wd, rdv;
	wire [2:0] mode;
	wire wr, rd, reg_on, l200, l910, dlp, xcvr, dpu, dppd, dmpd, comb, dir, idpd, idgp, idsrc, dmp;
	reg [23:0] v;
	integer failures = 0;
	integer checks = 0;
	integer i;
	// Clock, 25 ns period
	always #12.5 clk_sys_i = ~clk_sys_i;
	ccr_regs #(.VTMR_STEP_CYC(24'h000014), .LINE_PULSE_CYC(24'h000004)) dut_u (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdv),
		.boost_output_enable_i(boost), .boot_strap_pin_i(strap), .reset_low_pin_i(rst_n_pin), .usb_enable_pin_i(usben),
		.transmit_enable_low_i(tx_en_n), .line_se0_i(se0), .five_volt_regulator_on_o(reg_on), .limit_200ma_o(l200),
		.limit_910ua_o(l910), .data_line_pulse_timer_enable_o(dlp), .transceiver_enable_o(xcvr), .dp_var_pullup_o(dpu),
		.dp_pulldown_o(dppd), .dm_pulldown_o(dmpd), .interface_mode_o(mode), .combined_data_signalling_o(comb),
		.direction_select_o(dir), .ident_line_pulldown_o(idpd), .ident_line_ground_pulse_o(idgp),
		.ident_pullup_source_select_o(idsrc), .minus_line_pulse_o(dmp));
	ccr_host h (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wd),
		.reg_rdata_i(rdv));
	// Compare and count
	task chk(input [23:0] got, input [23:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task summarize;
		if (failures == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles needed
	initial begin
		#100000;
		failures = failures + 1;
		summarize;
	end
	initial begin
		tick(5);
		sys_rst_i = 1'b0;
		tick(6);
		h.rd(6'h05, v);
		chk(v, 24'h0E0060);
		chk({comb, dir}, 2'b11);
		chk(l200, 1'b1);
		h.wr(6'h06, 24'hFFFFFF);
		h.rd(6'h06, v);
		chk(v, 24'h000000);
		for (i = 0; i < 8; i = i + 1) begin
			h.wr(6'h05, {7'h00, i[2:0], 14'h1400});
			h.rd(6'h05, v);
			chk(v, {7'h00, i[2:0], 14'h1400});
			chk(mode, i[2:0]);
			chk(xcvr, i == 0);
		end
		// Pin control with pull override
		h.wr(6'h05, 24'h082000);
		chk(xcvr, 1'b0);
		chk({dlp, comb, dir}, 3'b000);
		usben = 1'b1;
		tick(3);
		chk({xcvr, dpu}, 2'b11);
		tx_en_n = 1'b0;
		rst_n_pin = 1'b0;
		tick(3);
		chk({xcvr, dpu}, 2'b00);
		h.wr(6'h05, 24'h000818);
		se0 = 1'b1;
		tick(3);
		chk({dpu, dppd, dmpd}, 3'b111);
		se0 = 1'b0;
		tick(3);
		chk(dpu, 1'b0);
		// Limit timer, code 2 lasts two steps
		h.wr(6'h05, 24'h000100);
		chk({reg_on, l910, l200}, 3'b110);
		for (i = 0; l910 === 1'b1 && i < 99; i = i + 1)
			tick(1);
		chk(i[23:0], 24'h000028);
		boost = 1'b1;
		tick(1);
		chk({reg_on, l200}, 2'b10);
		boost = 1'b0;
		// Code 7 holds the limit until the next write
		h.wr(6'h05, 24'h000380);
		tick(50);
		chk({reg_on, l910, l200}, 3'b110);
		h.wr(6'h05, 24'hF00000);
		tick(2);
		chk({idgp, dmp, idsrc, idpd}, 4'hF);
		tick(8);
		chk({idgp, dmp}, 2'b00);
		// Mid-run reset with the strap low
		strap = 1'b0;
		sys_rst_i = 1'b1;
		tick(5);
		sys_rst_i = 1'b0;
		tick(6);
		h.rd(6'h05, v);
		chk(v, 24'h080060);
		chk({comb, dir, idgp, dmp}, 4'h0);
		summarize;
	end
endmodule
